// ===== design/coeff_bank_pkg.sv
// package: register positions, reset values and widths of the coefficient bank
package coeff_bank_pkg;

  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned COEFF_W = 16;

  // ---------------------------------------------------------------------------
  // register positions on page 1
  // ---------------------------------------------------------------------------
  localparam logic [6:0] RIGHT_DEEMPH_NUM0_HIGH = 7'h2f;
  localparam logic [6:0] RIGHT_DEEMPH_NUM0_LOW  = 7'h30;
  localparam logic [6:0] RIGHT_DEEMPH_NUM1_HIGH = 7'h31;
  localparam logic [6:0] RIGHT_DEEMPH_NUM1_LOW  = 7'h32;
  localparam logic [6:0] RIGHT_DEEMPH_DEN1_HIGH = 7'h33;
  localparam logic [6:0] RIGHT_DEEMPH_DEN1_LOW  = 7'h34;
  localparam logic [6:0] SPATIAL_ATTEN_HIGH     = 7'h35;
  localparam logic [6:0] SPATIAL_ATTEN_LOW      = 7'h36;
  localparam logic [6:0] RESERVED_FIRST         = 7'h37;
  localparam logic [6:0] RESERVED_LAST          = 7'h40;
  localparam logic [6:0] LEFT_HPF_NUM0_HIGH     = 7'h41;
  localparam logic [6:0] LEFT_HPF_NUM0_LOW      = 7'h42;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_DEEMPH_NUM0_HIGH = 8'h00;
  localparam logic [7:0] RST_DEEMPH_NUM0_LOW  = 8'h55;
  localparam logic [7:0] RST_DEEMPH_NUM1_HIGH = 8'hf3;
  localparam logic [7:0] RST_DEEMPH_NUM1_LOW  = 8'h2d;
  localparam logic [7:0] RST_DEEMPH_DEN1_HIGH = 8'h53;
  localparam logic [7:0] RST_DEEMPH_DEN1_LOW  = 8'h7e;
  localparam logic [7:0] RST_ATTEN_HIGH       = 8'h7f;
  localparam logic [7:0] RST_ATTEN_LOW        = 8'hff;
  localparam logic [7:0] RST_HPF_NUM0_HIGH    = 8'h39;
  localparam logic [7:0] RST_HPF_NUM0_LOW     = 8'h55;
  localparam logic [7:0] RESERVED_VALUE       = 8'h00;

endpackage : coeff_bank_pkg

// ===== design/coeff_byte_reg.sv
// one 8-bit read/write coefficient byte with its own reset value
`timescale 1ns/1ps
`default_nettype none
module coeff_byte_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // write port
  input  wire logic       write_en,
  input  wire logic [7:0] write_data,
  // stored value
  output logic      [7:0] value
);

  logic [7:0] value_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      value_q <= RESET_VALUE;
    end else if (write_en) begin
      value_q <= write_data;
    end
  end

  assign value = value_q;

endmodule : coeff_byte_reg
`default_nettype wire

// ===== design/filter_coeff_reg_bank.sv
// page 1 coefficient register bank: de-emphasis, spatial attenuation, high-pass
`timescale 1ns/1ps
`default_nettype none

// Function
// - coefficient word is high byte then low byte
// - de-emphasis bytes at positions 47 through 52
// - de-emphasis tap zero low resets to 0x55
// - tap one bytes reset to 0xf3, 0x2d
// - denominator bytes reset to 0x53, 0x7e
// - attenuation pair at 53/54, resets 0x7f/0xff
// - positions 55 to 64 read zero only
// - high-pass tap zero high at 65, 0x39
// - high-pass tap zero low at 66, 0x55
module filter_coeff_reg_bank (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // register access, page 1 already selected by the control bus
  input  wire logic        page_one_sel,
  input  wire logic [6:0]  reg_addr,
  input  wire logic        reg_write,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // coefficient words to the filter datapaths
  output logic signed [15:0] right_deemph_numerator_tap_zero,
  output logic signed [15:0] right_deemph_numerator_tap_one,
  output logic signed [15:0] right_deemph_denominator_tap_one,
  output logic signed [15:0] spatial_atten_coeff,
  output logic signed [15:0] left_hpf_numerator_tap_zero
);

  // ---------------------------------------------------------------------------
  // register table
  // ---------------------------------------------------------------------------
  localparam int unsigned NUM_REGS = 10;

  localparam logic [6:0] REG_ADDR [NUM_REGS] = '{
    coeff_bank_pkg::RIGHT_DEEMPH_NUM0_HIGH,
    coeff_bank_pkg::RIGHT_DEEMPH_NUM0_LOW,
    coeff_bank_pkg::RIGHT_DEEMPH_NUM1_HIGH,
    coeff_bank_pkg::RIGHT_DEEMPH_NUM1_LOW,
    coeff_bank_pkg::RIGHT_DEEMPH_DEN1_HIGH,
    coeff_bank_pkg::RIGHT_DEEMPH_DEN1_LOW,
    coeff_bank_pkg::SPATIAL_ATTEN_HIGH,
    coeff_bank_pkg::SPATIAL_ATTEN_LOW,
    coeff_bank_pkg::LEFT_HPF_NUM0_HIGH,
    coeff_bank_pkg::LEFT_HPF_NUM0_LOW
  };

  localparam logic [7:0] REG_RESET [NUM_REGS] = '{
    coeff_bank_pkg::RST_DEEMPH_NUM0_HIGH,
    coeff_bank_pkg::RST_DEEMPH_NUM0_LOW,
    coeff_bank_pkg::RST_DEEMPH_NUM1_HIGH,
    coeff_bank_pkg::RST_DEEMPH_NUM1_LOW,
    coeff_bank_pkg::RST_DEEMPH_DEN1_HIGH,
    coeff_bank_pkg::RST_DEEMPH_DEN1_LOW,
    coeff_bank_pkg::RST_ATTEN_HIGH,
    coeff_bank_pkg::RST_ATTEN_LOW,
    coeff_bank_pkg::RST_HPF_NUM0_HIGH,
    coeff_bank_pkg::RST_HPF_NUM0_LOW
  };

  // which two byte positions pair into each coefficient word
  localparam int unsigned NUM_WORDS = NUM_REGS / 2;

  localparam int unsigned WORD_HIGH [NUM_WORDS] = '{0, 2, 4, 6, 8};
  localparam int unsigned WORD_LOW  [NUM_WORDS] = '{1, 3, 5, 7, 9};

  logic [7:0]          byte_value [NUM_REGS];
  logic [7:0]          rdata_q;
  logic [NUM_REGS-1:0] pos_hit;
  logic [NUM_REGS-1:0] pos_write;
  logic                reserved_hit;
  logic [15:0]         coeff_word [NUM_WORDS];

  // ---------------------------------------------------------------------------
  // position decode
  // ---------------------------------------------------------------------------
  // hit and strobe share one decode so the read and write paths can never
  // disagree about which byte a position names
  for (genvar i = 0; i < NUM_REGS; i++) begin : g_decode
    assign pos_hit[i]   = page_one_sel && (reg_addr == REG_ADDR[i]);
    assign pos_write[i] = pos_hit[i] && reg_write;
  end

  // the span decode only steers reads of the reserved positions to zero
  assign reserved_hit = page_one_sel
                     && (reg_addr >= coeff_bank_pkg::RESERVED_FIRST)
                     && (reg_addr <= coeff_bank_pkg::RESERVED_LAST);

  // ---------------------------------------------------------------------------
  // storage: one byte register per coefficient position, none for the reserved span
  // ---------------------------------------------------------------------------
  for (genvar i = 0; i < NUM_REGS; i++) begin : g_byte
    coeff_byte_reg #(
      .RESET_VALUE (REG_RESET[i])
    ) u_byte (
      .clock      (clock),
      .reset      (reset),
      .write_en   (pos_write[i]),
      .write_data (reg_wdata),
      .value      (byte_value[i])
    );
  end

  // ---------------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------------
  // registered so the read data is a flop output; valid the cycle after address.
  // reserved positions have no storage, so a stray host write there is harmless.
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_q <= coeff_bank_pkg::RESERVED_VALUE;
    end else if (reserved_hit) begin
      rdata_q <= coeff_bank_pkg::RESERVED_VALUE;
    end else begin
      rdata_q <= coeff_bank_pkg::RESERVED_VALUE;
      for (int k = 0; k < NUM_REGS; k++) begin
        if (pos_hit[k]) begin
          rdata_q <= byte_value[k];
        end
      end
    end
  end

  assign reg_rdata = rdata_q;

  // ---------------------------------------------------------------------------
  // coefficient words, high byte in the upper half
  // ---------------------------------------------------------------------------
  // no shadow copy: each byte takes effect alone, so a two-byte update shows
  // a mixed word until the other byte is written; software must tolerate that or mute first
  for (genvar w = 0; w < NUM_WORDS; w++) begin : g_word
    assign coeff_word[w] = {byte_value[WORD_HIGH[w]], byte_value[WORD_LOW[w]]};
  end

  assign right_deemph_numerator_tap_zero  = coeff_word[0];
  assign right_deemph_numerator_tap_one   = coeff_word[1];
  assign right_deemph_denominator_tap_one = coeff_word[2];
  assign spatial_atten_coeff              = coeff_word[3];
  assign left_hpf_numerator_tap_zero      = coeff_word[4];

endmodule : filter_coeff_reg_bank
`default_nettype wire

// ===== dv/coeff_bank_chk.sv
// checker: coefficient bank port assertions
`timescale 1ns/1ps
`default_nettype none
module coeff_bank_chk (
  // register access
  input wire logic               clock,
  input wire logic               reset,
  input wire logic               page_one_sel,
  input wire logic        [6:0]  reg_addr,
  input wire logic               reg_write,
  input wire logic        [7:0]  reg_wdata,
  input wire logic        [7:0]  reg_rdata,
  // coefficient words
  input wire logic signed [15:0] right_deemph_numerator_tap_one,
  input wire logic signed [15:0] spatial_atten_coeff
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_rst_tap_one: assert property ($fell(reset) |->
    right_deemph_numerator_tap_one == 16'hf32d) else $error("tap one reset");
  a_rst_atten: assert property ($fell(reset) |->
    spatial_atten_coeff == 16'h7fff) else $error("atten reset");
  a_wr_tap_high: assert property (page_one_sel && reg_write && reg_addr == 7'h31 |=>
    right_deemph_numerator_tap_one[15:8] == $past(reg_wdata)) else $error("tap one write");
  a_wr_atten_low: assert property (page_one_sel && reg_write && reg_addr == 7'h36 |=>
    spatial_atten_coeff[7:0] == $past(reg_wdata)) else $error("atten write");
  a_rsvd_reads: assert property (page_one_sel && reg_addr inside {[7'h37:7'h40]} |=>
    reg_rdata == 8'h00) else $error("reserved read");
  a_read_atten: assert property (page_one_sel && reg_addr == 7'h35 |=>
    reg_rdata == $past(spatial_atten_coeff[15:8])) else $error("atten read");
  a_idle_atten: assert property (!(page_one_sel && reg_write) |=>
    $stable(spatial_atten_coeff)) else $error("atten changed");
  a_page_off: assert property (!page_one_sel |=>
    $stable(right_deemph_numerator_tap_one)) else $error("page off write");
endmodule : coeff_bank_chk
bind filter_coeff_reg_bank coeff_bank_chk i_coeff_bank_chk (.*);
`default_nettype wire

// ===== dv/coeff_host.sv
// host model: page 1 register accesses, one per clock
`timescale 1ns/1ps
`default_nettype none
module coeff_host (
  // clock
  input  wire logic       clock,
  // register access
  output logic            page_one_sel = 1'b0,
  output logic      [6:0] reg_addr     = 7'h00,
  output logic            reg_write    = 1'b0,
  output logic      [7:0] reg_wdata    = 8'h00
);
  // a write aimed at the reserved span is turned into a read, never sent
  task automatic put(input logic s, input logic [6:0] a, input logic w, input logic [7:0] d);
    @(posedge clock);
    #2;
    page_one_sel = s;
    reg_addr = a;
    reg_write = w && !(a inside {[7'h37:7'h40]});
    reg_wdata = reg_write ? d : ~reg_wdata;
  endtask : put
endmodule : coeff_host
`default_nettype wire

// ===== dv/tb_filter_coeff_reg_bank.sv
// testbench: coefficient bank resets, read and write paths
`timescale 1ns/1ps
`default_nettype none
module tb_filter_coeff_reg_bank;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic page_one_sel, reg_write;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic signed [15:0] right_deemph_numerator_tap_zero, right_deemph_numerator_tap_one;
  logic signed [15:0] right_deemph_denominator_tap_one, spatial_atten_coeff;
  logic signed [15:0] left_hpf_numerator_tap_zero;
  int n_fail = 0;
  int comparisons = 0;
  logic [7:0] rst_tbl [20] = '{8'h00, 8'h55, 8'hf3, 8'h2d, 8'h53, 8'h7e, 8'h7f, 8'hff, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h39, 8'h55};
  logic [15:0] wrst [5] = '{16'h0055, 16'hf32d, 16'h537e, 16'h7fff, 16'h3955};
  function automatic logic [15:0] word_at(input int k);
    case (k)
      0: word_at = right_deemph_numerator_tap_zero;
      1: word_at = right_deemph_numerator_tap_one;
      2: word_at = right_deemph_denominator_tap_one;
      3: word_at = spatial_atten_coeff;
      default: word_at = left_hpf_numerator_tap_zero;
    endcase
  endfunction : word_at
  coeff_host i_coeff_host (.*);
  filter_coeff_reg_bank i_filter_coeff_reg_bank (.*);
  initial begin
    forever #12.5 clock = ~clock;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk_byte
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    i_coeff_host.put(1'b1, a, 1'b0, 8'h00);
    @(posedge clock);
    #1;
    chk_byte("reg_rdata", e, reg_rdata);
  endtask : rd
  // rows: every position 47 to 66, then the five words; wr selects written pattern
  task automatic sweep(input logic wr);
    logic [6:0] a;
    for (int i = 0; i < 20; i++) begin
      a = 7'h2f + 7'(i);
      rd(a, (wr && !(i inside {[8:17]})) ? {1'b1, a} : rst_tbl[i]);
    end
    for (int k = 0; k < 5; k++) begin
      a = (k < 4) ? 7'h2f + 7'(2 * k) : 7'h41;
      chk("word", wr ? {1'b1, a, 1'b1, 7'(a + 7'h01)} : wrst[k], word_at(k));
    end
  endtask : sweep
  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  initial begin
    repeat (2) @(posedge clock);
    #2 reset = 1'b0;
    sweep(1'b0);
    for (int i = 0; i < 20; i++) begin
      i_coeff_host.put(1'b1, 7'h2f + 7'(i), 1'b1, {1'b1, 7'h2f + 7'(i)});
    end
    sweep(1'b1);
    i_coeff_host.put(1'b0, 7'h2f, 1'b1, 8'h11);
    rd(7'h2f, 8'haf);
    rd(7'h10, 8'h00);
    #1 reset = 1'b1;
    repeat (2) @(posedge clock);
    #2 reset = 1'b0;
    sweep(1'b0);
    results();
  end
  initial begin
    #200us;
    n_fail++;
    results();
  end
endmodule : tb_filter_coeff_reg_bank
`default_nettype wire
